// file: inc/csd_pkg.sv
package csd_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CSD_OFS_CH2_LEVEL = 8'h20;
    localparam logic [7:0] CSD_OFS_CH3_LEVEL = 8'h21;
    localparam logic [7:0] CSD_OFS_MAKER = 8'h7e;
    localparam logic [7:0] CSD_OFS_PART = 8'h7f;
    localparam int CSD_CODE_MSB = 15;
    localparam int CSD_CODE_LSB = 11;
    localparam int CSD_RSVD_MSB = 10;
    localparam logic [4:0] CSD_EXCITE_RST = 5'h00;
    localparam logic [10:0] CSD_RSVD_VAL = 11'h000;
    localparam logic [15:0] CSD_UNMAPPED_VAL = 16'h0000;
    localparam logic [7:0] CSD_PART_PAD = 8'h00;
    // ------------------------------------------------------------
    // Channel select codes and conversion scaling
    // ------------------------------------------------------------
    localparam logic [1:0] CSD_SEL_CH2 = 2'h2;
    localparam logic [1:0] CSD_SEL_CH3 = 2'h3;
    localparam int CSD_REF_SHIFT = 4;
    // ------------------------------------------------------------
    // Serial port
    // ------------------------------------------------------------
    localparam logic [3:0] CSD_BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] CSD_IDX_ADDR = 2'h0;
    localparam logic [1:0] CSD_IDX_PTR = 2'h1;
    localparam logic [1:0] CSD_IDX_HI = 2'h2;
    localparam logic [1:0] CSD_IDX_LO = 2'h3;

    typedef struct packed {
        logic [4:0] code;
    } csd_excite_t;

    typedef enum logic [4:0] {
        CSD_IDLE = 5'h01,
        CSD_RX = 5'h02,
        CSD_ACK = 5'h04,
        CSD_TX = 5'h08,
        CSD_RACK = 5'h10
    } csd_state_t;
endpackage

// file: verilog/csd_conv_timer.sv
module csd_conv_timer
    import csd_pkg::*;
(
    input wire logic clk, // 125 MHz
    input wire logic resetn, // Async, active low
    input wire logic start, // Begin one conversion
    input wire logic ref_tick, // One pulse per channel_ref_clock period
    input wire logic [15:0] conversion_ref_count, // Reference count of channel
    output logic busy_q, // Conversion running
    output logic done_q // One-cycle end pulse
);
    logic [19:0] cnt_q;
    logic [19:0] target;
    logic [19:0] cnt_inc;

    assign target = {conversion_ref_count, 4'h0} >> (4 - CSD_REF_SHIFT);
    assign cnt_inc = cnt_q + 20'h00001;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 20'h00000;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start) begin
                cnt_q <= 20'h00000;
                busy_q <= 1'b1;
            end else if (busy_q && ref_tick) begin
                cnt_q <= cnt_inc;
                // Count zero ends on the first tick rather than hanging
                if (cnt_inc >= target) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
        end
    end

    property p_conv_len;
        @(posedge clk) disable iff (!resetn)
        (busy_q && !start && ref_tick && cnt_inc >= target) |=> (done_q && !busy_q);
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion end missed");

    property p_no_early_end;
        @(posedge clk) disable iff (!resetn)
        (busy_q && !start && (!ref_tick || cnt_inc < target)) |=> (busy_q && !done_q);
    endproperty
    a_no_early_end: assert property (p_no_early_end) else $error("conversion ended early");
endmodule

// file: verilog/csd_regs.sv
// Contract
// - Channel 2/3 levels only in four-channel parts
// - Channel 2 code bits 15:11, applied
// - Channel 3 code bits 15:11, applied
// - Code maps monotonically to drive current
// - Fixed 16-bit maker code, read-only
// - Fixed part code, per resolution variant
// - Sleep keeps every register
// - Shutdown loses configuration, host rewrites
// - Conversion lasts reference count times 16
module csd_regs
    import csd_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h2a, // Serial address
    parameter logic FOUR_CHAN = 1'b1, // Four-channel variant
    parameter logic HIGH_RES = 1'b1, // Higher-resolution variant
    parameter logic [15:0] MAKER_VAL = 16'ha5c3, // Arbitrary value
    parameter logic [7:0] PART_LO_VAL = 8'h21, // Arbitrary value
    parameter logic [7:0] PART_HI_VAL = 8'h22 // Arbitrary value
) (
    input wire logic clk, // 125 MHz
    input wire logic resetn, // Async, active low
    input wire logic scl_in, // Serial clock level
    input wire logic sda_in, // Serial data level
    output logic sda_out, // Always low, open drain
    output logic sda_oe_n, // Low while pulling data low
    input wire logic sleep, // Sleep mode
    input wire logic shutdown, // Shutdown mode
    input wire logic [1:0] active_chan, // Channel being served
    input wire logic settle_busy, // Active channel settling
    input wire logic conv_start, // Start conversion of active channel
    input wire logic ref_tick, // channel_ref_clock period pulse
    input wire logic [15:0] conversion_ref_count, // Active channel count
    output csd_excite_t drive_code_q, // Excite code to the sensor driver
    output logic conv_busy_q, // Conversion running
    output logic conv_done_q // Conversion end pulse
);
    csd_state_t state_q;
    logic scl_q;
    logic sda_q;
    logic [7:0] rx_q;
    logic [15:0] tx_q;
    logic [3:0] cnt_q;
    logic [1:0] idx_q;
    logic rw_q;
    logic [7:0] ptr_q;
    logic [7:0] hi_q;
    logic ack_q;
    csd_excite_t ch2_q;
    csd_excite_t ch3_q;
    logic [15:0] rd_data;
    logic [15:0] wr_data;
    logic wr_en;
    logic start_ev;
    logic stop_ev;
    logic scl_rise;
    logic scl_fall;
    logic [7:0] rx_byte;
    logic chan_on;

    // ------------------------------------------------------------
    // Bus events
    // ------------------------------------------------------------
    assign start_ev = scl_in && scl_q && sda_q && !sda_in;
    assign stop_ev = scl_in && scl_q && !sda_q && sda_in;
    assign scl_rise = scl_in && !scl_q;
    assign scl_fall = !scl_in && scl_q;
    assign rx_byte = rx_q;
    assign wr_data = {hi_q, rx_byte};
    assign wr_en = (state_q == CSD_RX) && scl_fall && (cnt_q == CSD_BITS_PER_BYTE)
        && (idx_q == CSD_IDX_LO) && !rw_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_data = CSD_UNMAPPED_VAL;
        if (ptr_q == CSD_OFS_CH2_LEVEL && FOUR_CHAN) begin
            rd_data = {ch2_q.code, CSD_RSVD_VAL};
        end else if (ptr_q == CSD_OFS_CH3_LEVEL && FOUR_CHAN) begin
            rd_data = {ch3_q.code, CSD_RSVD_VAL};
        end else if (ptr_q == CSD_OFS_MAKER) begin
            rd_data = MAKER_VAL;
        end else if (ptr_q == CSD_OFS_PART) begin
            rd_data = {CSD_PART_PAD, HIGH_RES ? PART_HI_VAL : PART_LO_VAL};
        end
    end

    // ------------------------------------------------------------
    // Serial slave
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= CSD_IDLE;
            rx_q <= 8'h00;
            tx_q <= 16'h0000;
            cnt_q <= 4'h0;
            idx_q <= CSD_IDX_ADDR;
            rw_q <= 1'b0;
            ptr_q <= 8'h00;
            hi_q <= 8'h00;
            ack_q <= 1'b0;
            sda_oe_n <= 1'b1;
        end else if (start_ev) begin
            // Repeated start keeps the pointer for the read phase
            state_q <= CSD_RX;
            cnt_q <= 4'h0;
            idx_q <= CSD_IDX_ADDR;
            sda_oe_n <= 1'b1;
        end else if (stop_ev) begin
            state_q <= CSD_IDLE;
            sda_oe_n <= 1'b1;
        end else begin
            case (state_q)
                CSD_RX: begin
                    if (scl_rise && cnt_q < CSD_BITS_PER_BYTE) begin
                        rx_q <= {rx_q[6:0], sda_in};
                        cnt_q <= cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == CSD_BITS_PER_BYTE) begin
                        cnt_q <= 4'h0;
                        state_q <= CSD_ACK;
                        sda_oe_n <= 1'b0;
                        case (idx_q)
                            CSD_IDX_ADDR: begin
                                if (rx_q[7:1] == DEV_ADDR) begin
                                    rw_q <= rx_q[0];
                                    idx_q <= CSD_IDX_PTR;
                                end else begin
                                    state_q <= CSD_IDLE;
                                    sda_oe_n <= 1'b1;
                                end
                            end
                            CSD_IDX_PTR: begin
                                ptr_q <= rx_q;
                                idx_q <= CSD_IDX_HI;
                            end
                            CSD_IDX_HI: begin
                                hi_q <= rx_q;
                                idx_q <= CSD_IDX_LO;
                            end
                            default: begin
                                idx_q <= CSD_IDX_HI;
                            end
                        endcase
                    end
                end
                CSD_ACK: begin
                    if (scl_fall) begin
                        if (rw_q && idx_q == CSD_IDX_PTR) begin
                            state_q <= CSD_TX;
                            sda_oe_n <= rd_data[15];
                            tx_q <= {rd_data[14:0], 1'b0};
                            cnt_q <= 4'h1;
                        end else begin
                            state_q <= CSD_RX;
                            sda_oe_n <= 1'b1;
                        end
                    end
                end
                CSD_TX: begin
                    if (scl_fall) begin
                        if (cnt_q == CSD_BITS_PER_BYTE) begin
                            state_q <= CSD_RACK;
                            sda_oe_n <= 1'b1;
                            cnt_q <= 4'h0;
                        end else begin
                            sda_oe_n <= tx_q[15];
                            tx_q <= {tx_q[14:0], 1'b0};
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                end
                CSD_RACK: begin
                    if (scl_rise) begin
                        ack_q <= !sda_in;
                    end else if (scl_fall) begin
                        // Bytes past the second read as zero
                        if (ack_q) begin
                            state_q <= CSD_TX;
                            sda_oe_n <= tx_q[15];
                            tx_q <= {tx_q[14:0], 1'b0};
                            cnt_q <= 4'h1;
                        end else begin
                            state_q <= CSD_IDLE;
                        end
                    end
                end
                default: begin
                    sda_oe_n <= 1'b1;
                end
            endcase
        end
    end

    assign sda_out = 1'b0;

    // ------------------------------------------------------------
    // Excitation registers
    // ------------------------------------------------------------
    // Sleep is not a term here, so contents simply hold through it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ch2_q.code <= CSD_EXCITE_RST;
            ch3_q.code <= CSD_EXCITE_RST;
        end else if (shutdown) begin
            ch2_q.code <= CSD_EXCITE_RST;
            ch3_q.code <= CSD_EXCITE_RST;
        end else if (wr_en && FOUR_CHAN) begin
            if (ptr_q == CSD_OFS_CH2_LEVEL) begin
                ch2_q.code <= wr_data[CSD_CODE_MSB:CSD_CODE_LSB];
            end else if (ptr_q == CSD_OFS_CH3_LEVEL) begin
                ch3_q.code <= wr_data[CSD_CODE_MSB:CSD_CODE_LSB];
            end
        end
    end

    // ------------------------------------------------------------
    // Drive current and conversion
    // ------------------------------------------------------------
    assign chan_on = (settle_busy || conv_busy_q) && !shutdown;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            drive_code_q.code <= CSD_EXCITE_RST;
        end else if (chan_on && active_chan == CSD_SEL_CH2) begin
            drive_code_q <= ch2_q;
        end else if (chan_on && active_chan == CSD_SEL_CH3) begin
            drive_code_q <= ch3_q;
        end else begin
            drive_code_q.code <= CSD_EXCITE_RST;
        end
    end

    csd_conv_timer u_timer (
        .clk(clk),
        .resetn(resetn),
        .start(conv_start && !sleep && !shutdown),
        .ref_tick(ref_tick),
        .conversion_ref_count(conversion_ref_count),
        .busy_q(conv_busy_q),
        .done_q(conv_done_q)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_wr_ch2;
        wr_en && !shutdown && ptr_q == CSD_OFS_CH2_LEVEL;
    endsequence
    sequence s_stop;
        scl_in && scl_q && !sda_q && sda_in;
    endsequence

    property p_ch2_write;
        @(posedge clk) disable iff (!resetn)
        s_wr_ch2 |=> (ch2_q.code == (FOUR_CHAN ? $past(wr_data[15:11]) : CSD_EXCITE_RST)
            || !FOUR_CHAN);
    endproperty
    a_ch2_write: assert property (p_ch2_write) else $error("ch2 code not stored");

    property p_ch3_write;
        @(posedge clk) disable iff (!resetn)
        (wr_en && !shutdown && FOUR_CHAN && ptr_q == CSD_OFS_CH3_LEVEL)
            |=> ch3_q.code == $past(wr_data[15:11]);
    endproperty
    a_ch3_write: assert property (p_ch3_write) else $error("ch3 code not stored");

    property p_rsvd_zero;
        @(posedge clk) disable iff (!resetn)
        (ptr_q == CSD_OFS_CH2_LEVEL || ptr_q == CSD_OFS_CH3_LEVEL) |-> rd_data[10:0] == 11'h000;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");

    property p_maker;
        @(posedge clk) disable iff (!resetn)
        ptr_q == CSD_OFS_MAKER |-> rd_data == MAKER_VAL;
    endproperty
    a_maker: assert property (p_maker) else $error("maker code wrong");

    property p_part;
        @(posedge clk) disable iff (!resetn)
        ptr_q == CSD_OFS_PART |-> rd_data[15:8] == 8'h00
            && rd_data[7:0] == (HIGH_RES ? PART_HI_VAL : PART_LO_VAL);
    endproperty
    a_part: assert property (p_part) else $error("part code wrong");

    property p_variant;
        @(posedge clk) disable iff (!resetn)
        (!FOUR_CHAN && ptr_q == CSD_OFS_CH2_LEVEL) |-> rd_data == 16'h0000;
    endproperty
    a_variant: assert property (p_variant) else $error("two-channel part shows ch2");

    property p_shutdown;
        @(posedge clk) disable iff (!resetn)
        shutdown |=> (ch2_q.code == 5'h00 && ch3_q.code == 5'h00 && drive_code_q.code == 5'h00);
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("config survived shutdown");

    property p_sleep_keep;
        @(posedge clk) disable iff (!resetn)
        (sleep && !shutdown && !wr_en) |=> ($stable(ch2_q) && $stable(ch3_q));
    endproperty
    a_sleep_keep: assert property (p_sleep_keep) else $error("register lost in sleep");

    property p_drive_apply;
        @(posedge clk) disable iff (!resetn)
        (settle_busy && !shutdown && active_chan == CSD_SEL_CH3)
            |=> drive_code_q.code == $past(ch3_q.code);
    endproperty
    a_drive_apply: assert property (p_drive_apply) else $error("ch3 drive not applied");

    property p_stop_release;
        @(posedge clk) disable iff (!resetn)
        s_stop |=> (sda_oe_n && state_q == CSD_IDLE);
    endproperty
    a_stop_release: assert property (p_stop_release) else $error("data held after stop");
endmodule

// file: testbench/csd_host_model.sv
module csd_host_model (
    input wire logic clk, // Bench clock
    input wire logic sda_in, // Resolved data wire
    output logic scl, // Serial clock from host
    output logic sda_rel, // High releases data, low pulls down
    output logic rd_valid, // One-cycle pulse with a read word
    output logic [15:0] rd_data, // Word read back
    output logic nack_q // Pulse when an ack was withheld
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF = 4;
    localparam logic [6:0] ADDR = 7'h2a;

    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
        rd_valid = 1'b0;
        rd_data = 16'h0000;
        nack_q = 1'b0;
    end

    // ------------------------------------------------------------
    // Bit level, changes only just after a clock edge
    // ------------------------------------------------------------
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic put_bit(input logic b, output logic s);
        sda_rel = b;
        hold(HALF);
        scl = 1'b1;
        hold(HALF);
        s = sda_in;
        scl = 1'b0;
    endtask

    task automatic start_cond();
        sda_rel = 1'b1;
        hold(HALF);
        scl = 1'b1;
        hold(HALF);
        sda_rel = 1'b0;
        hold(HALF);
        scl = 1'b0;
    endtask

    task automatic stop_cond();
        sda_rel = 1'b0;
        hold(HALF);
        scl = 1'b1;
        hold(HALF);
        sda_rel = 1'b1;
        hold(HALF);
    endtask

    // ------------------------------------------------------------
    // Byte and register level
    // ------------------------------------------------------------
    task automatic put_byte(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i], s);
        end
        put_bit(1'b1, s);
        if (s !== 1'b0) begin
            nack_q = 1'b1;
            hold(1);
            nack_q = 1'b0;
        end
    endtask

    task automatic get_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, s);
            b[i] = s;
        end
        put_bit(last, s);
    endtask

    // Sensors here are differential, so no divide-by-two select is owed
    task automatic wr_reg(input logic [7:0] ptr, input logic [15:0] d);
        start_cond();
        put_byte({ADDR, 1'b0});
        put_byte(ptr);
        put_byte(d[15:8]);
        put_byte(d[7:0]);
        stop_cond();
    endtask

    task automatic rd_reg(input logic [7:0] ptr);
        logic [7:0] hi;
        logic [7:0] lo;
        start_cond();
        put_byte({ADDR, 1'b0});
        put_byte(ptr);
        // Repeated start keeps the pointer
        start_cond();
        put_byte({ADDR, 1'b1});
        get_byte(1'b0, hi);
        get_byte(1'b1, lo);
        stop_cond();
        rd_data = {hi, lo};
        rd_valid = 1'b1;
        hold(1);
        rd_valid = 1'b0;
    endtask
endmodule

// file: testbench/csd_regs_tb.sv
module csd_regs_tb
    import csd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] MAKER = 16'h3c96; // Arbitrary value
    localparam logic [7:0] PART_HI = 8'h4b; // Arbitrary value
    localparam logic [7:0] PART_LO = 8'h5a; // Arbitrary value

    logic clk, resetn, scl, sda_rel, sda_in, sda_out, sda_oe_n;
    logic sleep, shutdown, settle_busy, conv_start, ref_tick;
    logic [1:0] active_chan;
    logic [15:0] ref_count;
    csd_excite_t drive_code_q;
    logic conv_busy_q, conv_done_q, rd_valid, nack_q;
    logic [15:0] rd_data;
    logic scl_lo, sda_rel_lo, sda_lo, sda_out_lo, sda_oe_lo_n, rd_valid_lo, nack_lo;
    logic [15:0] rd_data_lo;
    csd_excite_t drive_lo;
    logic [15:0] exp_q[$];
    int n_errors = 0;
    int total_checks = 0;

    // Pull-up on the data wire, either party may pull it low
    assign sda_in = sda_rel & (sda_oe_n | sda_out);

    csd_regs #(.MAKER_VAL(MAKER), .PART_HI_VAL(PART_HI)) csd_regs_i (
        .clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .sleep(sleep),
        .shutdown(shutdown), .active_chan(active_chan),
        .settle_busy(settle_busy), .conv_start(conv_start),
        .ref_tick(ref_tick), .conversion_ref_count(ref_count),
        .drive_code_q(drive_code_q), .conv_busy_q(conv_busy_q),
        .conv_done_q(conv_done_q));

    csd_host_model csd_host_model_i (
        .clk(clk), .sda_in(sda_in), .scl(scl), .sda_rel(sda_rel),
        .rd_valid(rd_valid), .rd_data(rd_data), .nack_q(nack_q));

    // Two-channel, lower-resolution build on a bus of its own
    assign sda_lo = sda_rel_lo & (sda_oe_lo_n | sda_out_lo);

    csd_regs #(.FOUR_CHAN(1'b0), .HIGH_RES(1'b0), .MAKER_VAL(MAKER), .PART_LO_VAL(PART_LO))
        csd_regs_lo_i (
        .clk(clk), .resetn(resetn), .scl_in(scl_lo), .sda_in(sda_lo),
        .sda_out(sda_out_lo), .sda_oe_n(sda_oe_lo_n), .sleep(sleep),
        .shutdown(shutdown), .active_chan(active_chan),
        .settle_busy(settle_busy), .conv_start(conv_start),
        .ref_tick(ref_tick), .conversion_ref_count(ref_count),
        .drive_code_q(drive_lo), .conv_busy_q(), .conv_done_q());

    csd_host_model csd_host_model_lo_i (
        .clk(clk), .sda_in(sda_lo), .scl(scl_lo), .sda_rel(sda_rel_lo),
        .rd_valid(rd_valid_lo), .rd_data(rd_data_lo), .nack_q(nack_lo));

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] ptr, input logic [15:0] exp);
        exp_q.push_back(exp);
        csd_host_model_i.rd_reg(ptr);
    endtask

    task automatic rd_two(input logic [7:0] ptr, input logic [15:0] exp);
        exp_q.push_back(exp);
        csd_host_model_lo_i.rd_reg(ptr);
    endtask

    always @(posedge clk) begin
        if (rd_valid === 1'b1 || rd_valid_lo === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(16'h0001, 16'h0000);
            end else if (rd_valid === 1'b1) begin
                check(rd_data, exp_q.pop_front());
            end else begin
                check(rd_data_lo, exp_q.pop_front());
            end
        end
        if (nack_q === 1'b1 || nack_lo === 1'b1) begin
            check(16'h0001, 16'h0000);
        end
    end

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        #600000;
        check(16'h0001, 16'h0000);
        stop_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [4:0] codes[4];
        logic [4:0] c;
        resetn = 1'b0;
        sleep = 1'b0;
        shutdown = 1'b0;
        active_chan = 2'h0;
        settle_busy = 1'b0;
        conv_start = 1'b0;
        ref_tick = 1'b0;
        ref_count = 16'h0000;
        codes = '{5'h00, 5'h01, 5'h02, 5'h1f};
        void'($urandom(32'hb471));
        hold(16);
        resetn = 1'b1;
        hold(2);
        rd(CSD_OFS_CH2_LEVEL, 16'h0000);
        rd(CSD_OFS_CH3_LEVEL, 16'h0000);
        rd(CSD_OFS_MAKER, MAKER);
        rd(CSD_OFS_PART, {CSD_PART_PAD, PART_HI});
        rd(8'h40, CSD_UNMAPPED_VAL);
        // Two-channel build ignores level writes, lower-resolution part code
        csd_host_model_lo_i.wr_reg(CSD_OFS_CH2_LEVEL, 16'hffff);
        csd_host_model_lo_i.wr_reg(CSD_OFS_CH3_LEVEL, 16'hffff);
        rd_two(CSD_OFS_CH2_LEVEL, CSD_UNMAPPED_VAL);
        rd_two(CSD_OFS_CH3_LEVEL, CSD_UNMAPPED_VAL);
        rd_two(CSD_OFS_PART, {CSD_PART_PAD, PART_LO});
        rd_two(CSD_OFS_MAKER, MAKER);
        // Random reserved bits must never read back
        for (int ch = 0; ch < 2; ch++) begin
            for (int k = 0; k < 4; k++) begin
                c = codes[k];
                csd_host_model_i.wr_reg(8'h20 + 8'(ch), {c, 11'($urandom)});
                rd(8'h20 + 8'(ch), {c, CSD_RSVD_VAL});
                active_chan = 2'h2 + 2'(ch);
                settle_busy = 1'b1;
                hold(2);
                check(16'(drive_code_q.code), 16'(c));
                check(16'(drive_lo.code), 16'h0000);
                settle_busy = 1'b0;
                hold(2);
                check(16'(drive_code_q.code), 16'h0000);
            end
        end
        // Mid-range codes keep the sensor amplitude in band
        csd_host_model_i.wr_reg(CSD_OFS_CH2_LEVEL, 16'h7fff);
        csd_host_model_i.wr_reg(CSD_OFS_CH3_LEVEL, 16'ha800);
        csd_host_model_i.wr_reg(CSD_OFS_MAKER, 16'hffff);
        csd_host_model_i.wr_reg(CSD_OFS_PART, 16'hffff);
        rd(CSD_OFS_CH2_LEVEL, 16'h7800);
        rd(CSD_OFS_MAKER, MAKER);
        rd(CSD_OFS_PART, {CSD_PART_PAD, PART_HI});
        sleep = 1'b1;
        conv_start = 1'b1;
        hold(1);
        conv_start = 1'b0;
        hold(1);
        check(16'(conv_busy_q), 16'h0000);
        rd(CSD_OFS_CH2_LEVEL, 16'h7800);
        rd(CSD_OFS_CH3_LEVEL, 16'ha800);
        sleep = 1'b0;
        // Conversion of 2 x 16 reference ticks with channel 2 driven
        active_chan = CSD_SEL_CH2;
        ref_count = 16'h0002;
        conv_start = 1'b1;
        hold(1);
        conv_start = 1'b0;
        check(16'(conv_busy_q), 16'h0001);
        hold(1);
        check(16'(drive_code_q.code), 16'h000f);
        for (int t = 0; t < 31; t++) begin
            ref_tick = 1'b1;
            hold(1);
            ref_tick = 1'b0;
            hold(1);
        end
        check(16'({conv_busy_q, conv_done_q}), 16'h0002);
        ref_tick = 1'b1;
        hold(1);
        check(16'({conv_busy_q, conv_done_q}), 16'h0001);
        ref_tick = 1'b0;
        hold(1);
        check(16'(conv_done_q), 16'h0000);
        // Shutdown drops the codes, host then rewrites
        active_chan = CSD_SEL_CH3;
        settle_busy = 1'b1;
        shutdown = 1'b1;
        hold(3);
        check(16'(drive_code_q.code), 16'h0000);
        shutdown = 1'b0;
        settle_busy = 1'b0;
        rd(CSD_OFS_CH2_LEVEL, 16'h0000);
        rd(CSD_OFS_CH3_LEVEL, 16'h0000);
        csd_host_model_i.wr_reg(CSD_OFS_CH2_LEVEL, 16'h7c00);
        rd(CSD_OFS_CH2_LEVEL, 16'h7800);
        // Second reset in mid-run
        resetn = 1'b0;
        hold(2);
        resetn = 1'b1;
        hold(2);
        rd(CSD_OFS_CH2_LEVEL, 16'h0000);
        for (int i = 0; i < 2000 && exp_q.size() > 0; i++) begin
            hold(1);
        end
        if (exp_q.size() > 0) begin
            check(16'h0001, 16'h0000);
        end
        stop_test();
    end
endmodule
